// ==== rtl/xoe_pkg.sv ====
// Package: opcodes, phases and constants for the xor and extension decoder
package xoe_pkg;
	localparam int          XOE_DW            = 8;
	localparam int          XOE_IW            = 16;
	localparam int          XOE_PW            = 12;
	localparam logic [7:0]  XOE_OPC_XORLIT    = 8'h0a;
	localparam logic [5:0]  XOE_OPC_XORFILE   = 6'h06;
	localparam logic [7:0]  XOE_OPC_ADDPTR    = 8'he8;
	localparam logic [7:0]  XOE_OPC_SUBPTR    = 8'he9;
	localparam logic [7:0]  XOE_OPC_PUSHLIT   = 8'hea;
	localparam logic [7:0]  XOE_OPC_MOVSX     = 8'heb;
	localparam logic [15:0] XOE_OPC_CALLW     = 16'h0014;
	localparam logic [7:0]  XOE_ILO_MAX       = 8'h5f;
	localparam logic [7:0]  XOE_ACC_HI_BASE   = 8'h60;
	localparam logic [3:0]  XOE_ACC_HI_BANK   = 4'hf;
	localparam logic [1:0]  XOE_PTR_TWO       = 2'h2;
	localparam logic [1:0]  XOE_PTR_RET       = 2'h3;
	localparam int          XOE_BIT_DEST      = 9;
	localparam int          XOE_BIT_ACC       = 8;
	localparam int          XOE_NUM_PTR       = 3;
	localparam logic [7:0]  XOE_W_RST         = 8'h00;
	localparam logic [11:0] XOE_PTR_RST       = 12'h000;
	typedef enum logic [1:0] {
		XOE_Q1,
		XOE_Q2,
		XOE_Q3,
		XOE_Q4
	} xoe_phase_e;
endpackage

// ==== rtl/xoe_phase_gen.sv ====
// Four-phase instruction cycle generator
`timescale 1ns/1ps
module xoe_phase_gen
	import xoe_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	output xoe_pkg::xoe_phase_e phase,
	output logic             cyc_end
);
	xoe_phase_e phase_q;
	xoe_phase_e phase_d;

	always_comb begin
		case (phase_q)
			XOE_Q1:  phase_d = XOE_Q2;
			XOE_Q2:  phase_d = XOE_Q3;
			XOE_Q3:  phase_d = XOE_Q4;
			default: phase_d = XOE_Q1;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			phase_q <= XOE_Q1;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign phase   = phase_q;
	assign cyc_end = (phase_q == XOE_Q4);
endmodule

// ==== rtl/xoe_core.sv ====
// Decode and execute of the xor instructions and the extended-set gate
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module xoe_core
	import xoe_pkg::*;
#(
	parameter int DW = XOE_DW,
	parameter int PW = XOE_PW
)(
	input  wire logic          ref_clk,
	input  wire logic          rstn,
	input  wire logic [15:0]   instr_word,
	input  wire logic          instr_valid,
	input  wire logic          extended_set_config_bit,
	input  wire logic [3:0]    bank_select_reg,
	input  wire logic [DW-1:0] mem_rdata,
	output logic [PW-1:0]      mem_addr,
	output logic [DW-1:0]      mem_wdata,
	output logic               mem_rd,
	output logic               mem_wr,
	output logic [DW-1:0]      working_register,
	output logic               negative_flag,
	output logic               zero_flag,
	output logic [PW-1:0]      pointer_zero,
	output logic [PW-1:0]      pointer_one,
	output logic [PW-1:0]      pointer_two,
	output logic               return_req,
	output logic               ext_active,
	output logic               illegal_op,
	output xoe_pkg::xoe_phase_e phase
);
	// Elaboration checks: byte datapath, 12 address bits for bank and offset
	if (DW != 8) begin
		$error("xoe_core: data width must be 8");
	end
	if (PW < 12) begin
		$error("xoe_core: address width below 12");
	end

	logic cyc_end;

	xoe_phase_gen u_phase (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.phase   (phase),
		.cyc_end (cyc_end)
	);

	//////////////////////////////////////////////////////////////////////////
	// Extension gate, caught once after reset release
	logic ext_q;
	logic ext_d;
	logic ext_seen_q;
	logic ext_seen_d;

	always_comb begin
		ext_d      = ext_q;
		ext_seen_d = 1'b1;
		if (!ext_seen_q) begin
			ext_d = extended_set_config_bit;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ext_q      <= 1'b0;
			ext_seen_q <= 1'b0;
		end else begin
			ext_q      <= ext_d;
			ext_seen_q <= ext_seen_d;
		end
	end

	assign ext_active = ext_q;

	//////////////////////////////////////////////////////////////////////////
	// Decode, latched in Q1 so the word may change during the cycle
	logic [15:0] ir_q;
	logic [15:0] ir_d;
	logic        irv_q;
	logic        irv_d;

	always_comb begin
		ir_d  = ir_q;
		irv_d = irv_q;
		if (phase == XOE_Q1) begin
			ir_d  = instr_word;
			irv_d = instr_valid;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ir_q  <= 16'h0000;
			irv_q <= 1'b0;
		end else begin
			ir_q  <= ir_d;
			irv_q <= irv_d;
		end
	end

	// Fields are common to every opcode family
	logic [7:0] f_lit8;
	logic [5:0] f_lit6;
	logic [1:0] f_ptr;
	logic       f_dest;
	logic       f_acc;
	assign f_lit8 = ir_q[7:0];
	assign f_lit6 = ir_q[5:0];
	assign f_ptr  = ir_q[7:6];
	assign f_dest = ir_q[XOE_BIT_DEST];
	assign f_acc  = ir_q[XOE_BIT_ACC];

	logic is_xlit;
	logic is_xfile;
	logic is_add;
	logic is_sub;
	logic is_push;
	logic is_movs;
	logic is_callw;
	assign is_xlit  = irv_q && (ir_q[15:8] == XOE_OPC_XORLIT);
	assign is_xfile = irv_q && (ir_q[15:10] == XOE_OPC_XORFILE);
	assign is_add   = irv_q && ext_q && (ir_q[15:8] == XOE_OPC_ADDPTR);
	assign is_sub   = irv_q && ext_q && (ir_q[15:8] == XOE_OPC_SUBPTR);
	assign is_push  = irv_q && ext_q && (ir_q[15:8] == XOE_OPC_PUSHLIT);
	assign is_movs  = irv_q && ext_q && (ir_q[15:8] == XOE_OPC_MOVSX);
	assign is_callw = irv_q && ext_q && (ir_q == XOE_OPC_CALLW);

	// Extended opcodes with the set off are refused, not run as something else
	// Refusal only raises the flag; every extended execute path is gated by ext_q
	logic ext_pat;
	assign ext_pat = irv_q && ((ir_q[15:10] == 6'h3a) ||
		(ir_q == XOE_OPC_CALLW));
	assign illegal_op = ext_pat && !ext_q;

	//////////////////////////////////////////////////////////////////////////
	// Operand address resolution
	logic [PW-1:0] ptr_q [XOE_NUM_PTR];
	logic [PW-1:0] ptr_d [XOE_NUM_PTR];
	logic [PW-1:0] f_addr;

	always_comb begin
		if (f_acc) begin
			f_addr = PW'({bank_select_reg, f_lit8});
		end else if (ext_q && f_lit8 <= XOE_ILO_MAX) begin
			// Offset from pointer two, so stack frames need no bank switching
			f_addr = ptr_q[XOE_PTR_TWO] +
				PW'(f_lit8);
		end else if (f_lit8 >= XOE_ACC_HI_BASE) begin
			// Upper access half reaches the special function bank
			f_addr = PW'({XOE_ACC_HI_BANK, f_lit8});
		end else begin
			// Lower access half is the start of bank zero
			f_addr = PW'(f_lit8);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Pointer arithmetic shared by the add and subtract forms; the two
	// return forms always land on pointer two whatever the field says
	logic [1:0]    ptr_idx;
	logic [PW-1:0] ptr_base;
	logic [PW-1:0] ptr_step;
	logic [PW-1:0] ptr_next;

	always_comb begin
		ptr_idx  = (f_ptr == XOE_PTR_RET) ? XOE_PTR_TWO : f_ptr;
		ptr_base = ptr_q[ptr_idx];
		ptr_step = PW'(f_lit6);
		if (is_sub) begin
			ptr_next = ptr_base - ptr_step;
		end else begin
			ptr_next = ptr_base + ptr_step;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Execute: read in Q2, process in Q3, write in Q4
	logic [DW-1:0] w_q;
	logic [DW-1:0] w_d;
	logic [DW-1:0] opnd_q;
	logic [DW-1:0] opnd_d;
	logic [DW-1:0] res_q;
	logic [DW-1:0] res_d;
	logic          n_q;
	logic          n_d;
	logic          z_q;
	logic          z_d;
	logic          ret_q;
	logic          ret_d;

	always_comb begin
		opnd_d = opnd_q;
		res_d  = res_q;
		w_d    = w_q;
		n_d    = n_q;
		z_d    = z_q;
		ret_d  = 1'b0;
		for (int i = 0; i < XOE_NUM_PTR; i++) begin
			ptr_d[i] = ptr_q[i];
		end
		case (phase)
			XOE_Q2: begin
				if (is_xlit) begin
					opnd_d = f_lit8;
				end else if (is_xfile) begin
					opnd_d = mem_rdata;
				end
			end
			XOE_Q3: begin
				res_d = w_q ^ opnd_q;
			end
			XOE_Q4: begin
				if (is_xlit || is_xfile) begin
					n_d = res_q[DW-1];
					z_d = (res_q == '0);
				end
				if (is_xlit || (is_xfile && !f_dest)) begin
					w_d = res_q;
				end
				if (is_add || is_sub) begin
					ptr_d[ptr_idx] = ptr_next;
					ret_d = (f_ptr == XOE_PTR_RET);
				end
				if (is_push) begin
					ptr_d[XOE_PTR_TWO] = ptr_q[XOE_PTR_TWO] - PW'(1);
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			w_q    <= XOE_W_RST;
			opnd_q <= '0;
			res_q  <= '0;
			n_q    <= 1'b0;
			z_q    <= 1'b0;
			ret_q  <= 1'b0;
			for (int i = 0; i < XOE_NUM_PTR; i++) begin
				ptr_q[i] <= XOE_PTR_RST;
			end
		end else begin
			w_q    <= w_d;
			opnd_q <= opnd_d;
			res_q  <= res_d;
			n_q    <= n_d;
			z_q    <= z_d;
			ret_q  <= ret_d;
			for (int i = 0; i < XOE_NUM_PTR; i++) begin
				ptr_q[i] <= ptr_d[i];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Data memory strobes; push writes its literal at pointer two
	// Xor write data is the registered result, steady through all of Q4
	always_comb begin
		mem_rd    = 1'b0;
		mem_wr    = 1'b0;
		mem_addr  = f_addr;
		mem_wdata = res_q;
		if (is_push) begin
			mem_addr  = ptr_q[XOE_PTR_TWO];
			mem_wdata = f_lit8;
			mem_wr    = (phase == XOE_Q4);
		end else if (is_xfile) begin
			mem_rd = (phase == XOE_Q2);
			mem_wr = (phase == XOE_Q4) && f_dest;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops
	assign working_register = w_q;
	assign negative_flag    = n_q;
	assign zero_flag        = z_q;
	assign pointer_zero     = ptr_q[0];
	assign pointer_one      = ptr_q[1];
	assign pointer_two      = ptr_q[XOE_PTR_TWO];
	// Return pulses one clock after Q4; the fetch stage pops its stack
	assign return_req       = ret_q;
	// Two-word moves and indirect call are decoded but run by the fetch stage
	logic unused_ok;
	assign unused_ok = is_movs ^ is_callw ^ cyc_end;
endmodule

// ==== testbench/xoe_core_monitor.sv ====
// Checker on the ports of the xor and extension decoder
`timescale 1ns/1ps
module xoe_core_monitor
	import xoe_pkg::*;
#(
	parameter int DW = XOE_DW,
	parameter int PW = XOE_PW
)(
	input wire logic            ref_clk,
	input wire logic            rstn,
	input wire logic            mem_rd,
	input wire logic            mem_wr,
	input wire logic [DW-1:0]   working_register,
	input wire logic            negative_flag,
	input wire logic            zero_flag,
	input wire logic            return_req,
	input wire logic [PW-1:0]   pointer_two,
	input wire logic            ext_active,
	input wire logic            illegal_op,
	input wire xoe_pkg::xoe_phase_e phase
);
	import xoe_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////
	property p_cyc; phase == XOE_Q4 |=> phase == XOE_Q1; endproperty
	a_cyc: assert property (p_cyc) else $error("phase did not wrap");
	property p_rd; mem_rd |-> phase == XOE_Q2; endproperty
	a_rd: assert property (p_rd) else $error("read off Q2");
	property p_wr; mem_wr |-> phase == XOE_Q4; endproperty
	a_wr: assert property (p_wr) else $error("write off Q4");
	property p_wst; phase != XOE_Q4 |=> $stable(working_register); endproperty
	a_wst: assert property (p_wst) else $error("W moved early");
	property p_fst;
		phase != XOE_Q4 |=> $stable({negative_flag, zero_flag});
	endproperty
	a_fst: assert property (p_fst) else $error("flags moved early");
	// Only xor writes W here, so a change of W must carry matching flags
	property p_nz;
		$changed(working_register) |-> (zero_flag == (working_register == '0))
			&& (negative_flag == working_register[DW-1]);
	endproperty
	a_nz: assert property (p_nz) else $error("flags wrong");
	property p_ret; return_req |-> ext_active ##1 !return_req; endproperty
	a_ret: assert property (p_ret) else $error("bad return pulse");
	property p_ill; illegal_op |-> !ext_active; endproperty
	a_ill: assert property (p_ill) else $error("illegal while on");
	// A refused opcode must leave pointer two alone and raise no return
	property p_ilx;
		illegal_op && phase == XOE_Q4 |=> $stable(pointer_two) && !return_req;
	endproperty
	a_ilx: assert property (p_ilx) else $error("refused op acted");
	// Config bit is caught one edge after release, so skip two edges
	property p_ext; $past(rstn, 2) |-> $stable(ext_active); endproperty
	a_ext: assert property (p_ext) else $error("ext moved");
	c_wr: cover property (mem_wr);
	c_ret: cover property (return_req);
	c_ill: cover property (illegal_op);
endmodule

bind xoe_core xoe_core_monitor #(.DW(DW), .PW(PW)) u_mon (.*);

// ==== testbench/xoe_mem_model.sv ====
// Data memory model on the far side of the decoder
`timescale 1ns/1ps
module xoe_mem_model (
	input  wire logic        ref_clk,
	input  wire logic [11:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] ram [4096];
	logic [7:0] last = 8'h00;
	// Off-cycle reads show a toggled value so stale data cannot pass
	assign mem_rdata = mem_rd ? ram[mem_addr] : ~last;
	always @(posedge ref_clk) begin
		if (mem_rd)
			last <= mem_rdata;
		if (mem_wr)
			ram[mem_addr] <= mem_wdata;
	end
endmodule

// ==== testbench/xoe_core_tb.sv ====
// Testbench for the xor and extension decoder
`timescale 1ns/1ps
module xoe_core_tb;
	import xoe_pkg::*;
	logic        ref_clk = 0, rstn = 0, instr_valid = 0;
	logic        extended_set_config_bit = 0;
	logic [15:0] instr_word = '0;
	logic [3:0]  bank_select_reg = 4'h3;
	logic [7:0]  mem_rdata, mem_wdata, working_register;
	logic [11:0] mem_addr, pointer_zero, pointer_one, pointer_two;
	logic        mem_rd, mem_wr, negative_flag, zero_flag, ill;
	logic        return_req, ext_active, illegal_op;
	xoe_phase_e  phase;
	int          num_errors = 0;
	int          checks_done = 0;
	always #20 ref_clk = ~ref_clk;
	xoe_core dut (
		.ref_clk                 (ref_clk),
		.rstn                    (rstn),
		.instr_word              (instr_word),
		.instr_valid             (instr_valid),
		.extended_set_config_bit (extended_set_config_bit),
		.bank_select_reg         (bank_select_reg),
		.mem_rdata               (mem_rdata),
		.mem_addr                (mem_addr),
		.mem_wdata               (mem_wdata),
		.mem_rd                  (mem_rd),
		.mem_wr                  (mem_wr),
		.working_register        (working_register),
		.negative_flag           (negative_flag),
		.zero_flag               (zero_flag),
		.pointer_zero            (pointer_zero),
		.pointer_one             (pointer_one),
		.pointer_two             (pointer_two),
		.return_req              (return_req),
		.ext_active              (ext_active),
		.illegal_op              (illegal_op),
		.phase                   (phase)
	);
	xoe_mem_model mem (
		.ref_clk   (ref_clk),
		.mem_addr  (mem_addr),
		.mem_wdata (mem_wdata),
		.mem_rd    (mem_rd),
		.mem_wr    (mem_wr),
		.mem_rdata (mem_rdata)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic rst(input logic c);
		@(posedge ref_clk);
		rstn <= 0;
		extended_set_config_bit <= c;
		repeat (3) @(posedge ref_clk);
		rstn <= 1;
		// Config bit is caught at the first edge after release
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	// Valid is shown for the Q1 cycle only, so the word runs exactly once
	task automatic ex(input logic [15:0] w);
		while (phase !== XOE_Q4)
			@(negedge ref_clk);
		@(posedge ref_clk);
		instr_word <= w;
		instr_valid <= 1;
		@(posedge ref_clk);
		instr_valid <= 0;
		@(negedge ref_clk);
		ill = illegal_op;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_lit;
		ex(16'h0aaf);
		chk(working_register, 12'h0af);
		chk({negative_flag, zero_flag}, 12'h002);
		ex(16'h0aaf);
		chk({working_register, negative_flag, zero_flag}, 12'h001);
		chk(ext_active, 12'h000);
	endtask
	task automatic t_file;
		mem.ram[12'h310] = 8'h35;
		mem.ram[12'hf80] = 8'h5a;
		ex(16'h1910);
		chk(working_register, 12'h035);
		ex(16'h1a80);
		chk(mem.ram[12'hf80], 12'h06f);
		chk(working_register, 12'h035);
	endtask
	task automatic t_ill;
		ex(16'he8a3);
		chk(ill, 12'h001);
		chk(pointer_two, 12'h000);
	endtask
	task automatic t_ext;
		rst(1);
		chk(ext_active, 12'h001);
		ex(16'he8a3);
		chk(pointer_two, 12'h023);
		ex(16'he8c5);
		chk(return_req, 12'h001);
		chk(pointer_two, 12'h028);
		mem.ram[12'h02d] = 8'h11;
		ex(16'h1805);
		chk(working_register, 12'h011);
		mem.ram[12'hf60] = 8'h0f;
		ex(16'h1860);
		chk(working_register, 12'h01e);
		ex(16'hea77);
		chk(mem.ram[12'h028], 12'h077);
		chk(pointer_two, 12'h027);
		ex(16'he905);
		chk(pointer_zero, 12'hffb);
		chk(return_req, 12'h000);
		ex(16'he841);
		chk(pointer_one, 12'h001);
		ex(16'he9c8);
		chk(pointer_two, 12'h01f);
		chk(return_req, 12'h001);
	endtask
	initial begin
		rst(0);
		t_lit;
		t_file;
		t_ill;
		t_ext;
		conclude;
	end
	initial begin
		#100000;
		num_errors++;
		conclude;
	end
endmodule
